/* File: hdl/ccdh_config.v */
`timescale 1ns/1ps
`include "ccdh_consts.vh"

// What this block does
// [RULE1] phase-A polarity bit inverts clock pair
// [RULE2] phase-A rise and fall positions, six bits
// [RULE3] four horizontal drive strengths, zero disables
// [RULE4] reset-gate polarity bit inverts waveform
// [RULE5] reset-gate rise and fall positions
// [RULE6] reset-gate drive strength, default two
// [RULE7] reference and data sample positions
// [RULE8] operating mode split over two addresses
// [RULE9] two-bit power state selection
// [RULE10] bit two disables black clamp loop
// [RULE11] software writes fixed test-mode bits
// [RULE12] control mode at address six, reset zero
// [RULE13] three-bit colour mode selection
// [RULE14] bit three enables pixel gain amp
// [RULE15] bit four selects output latching
// [RULE16] bit five tri-states converter outputs
// [RULE17] pixel period divided into 48 steps
// [RULE18] positions are quadrant plus 0..11
// [RULE19] second and fourth clocks are complements
// [RULE20] clocks rise, fall, then optional inversion
module ccdh_config (
    // clock and reset
    input  wire       clk,
    input  wire       rstn,
    // serial register port
    input  wire       wr_en,
    input  wire [7:0] wr_addr,
    input  wire [7:0] wr_data,
    input  wire       rd_en,
    input  wire [7:0] rd_addr,
    output reg  [7:0] rd_data,
    output reg        rd_valid,
    // pixel grid
    input  wire       pixel_start,
    output reg  [5:0] edge_step,
    // high-speed clocks
    output reg        hclk_phase_a,
    output reg        hclk_phase_a_inv,
    output reg        hclk_phase_b,
    output reg        hclk_phase_b_inv,
    output reg        reset_gate_clk,
    output reg        reference_sample_strobe,
    output reg        data_sample_strobe,
    // driver strengths, zero means driver off
    output reg  [2:0] hclk_a_drv,
    output reg  [2:0] hclk_a_inv_drv,
    output reg  [2:0] hclk_b_drv,
    output reg  [2:0] hclk_b_inv_drv,
    output reg  [2:0] reset_gate_drv,
    output reg        hclk_a_drv_en,
    output reg        hclk_a_inv_drv_en,
    output reg        hclk_b_drv_en,
    output reg        hclk_b_inv_drv_en,
    output reg        reset_gate_drv_en,
    // front-end controls
    output reg  [1:0] power_state,
    output reg        power_full,
    output reg        power_fast_recovery,
    output reg        power_ref_standby,
    output reg        power_shutdown,
    output reg        black_clamp_en,
    output reg  [2:0] color_mode,
    output reg        pixel_gain_amp_en,
    output reg        output_latch_en,
    output reg        adc_out_en
);

    // ****************************************
    // register storage
    // ****************************************
    reg [7:0] operating_mode;
    reg [5:0] control_mode;
    reg       hclk_a_polarity;
    reg [5:0] hclk_a_rise_position;
    reg [5:0] hclk_a_fall_position;
    reg [2:0] hclk_a_drive_strength;
    reg [2:0] hclk_a_inv_drive_strength;
    reg [2:0] hclk_b_drive_strength;
    reg [2:0] hclk_b_inv_drive_strength;
    reg       reset_gate_polarity;
    reg [5:0] reset_gate_rise_position;
    reg [5:0] reset_gate_fall_position;
    reg [2:0] reset_gate_drive_strength;
    reg [5:0] reference_sample_position;
    reg [5:0] data_sample_position;
    reg [7:0] next_rd_data;
    reg [5:0] step;
    wire      wave_ha;
    wire      wave_rg;
    wire      wave_ref;
    wire      wave_dat;
    wire [5:0] ref_fall;
    wire [5:0] dat_fall;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            operating_mode            <= `CCDH_RST_OPMODE; // [RULE8]
            control_mode              <= `CCDH_RST_CTLMODE; // [RULE12]
            hclk_a_polarity           <= `CCDH_RST_POL; // [RULE1]
            hclk_a_rise_position      <= `CCDH_RST_HA_RISE; // [RULE2]
            hclk_a_fall_position      <= `CCDH_RST_HA_FALL; // [RULE2]
            hclk_a_drive_strength     <= `CCDH_RST_H_DRV; // [RULE3]
            hclk_a_inv_drive_strength <= `CCDH_RST_H_DRV; // [RULE3]
            hclk_b_drive_strength     <= `CCDH_RST_H_DRV; // [RULE3]
            hclk_b_inv_drive_strength <= `CCDH_RST_H_DRV; // [RULE3]
            reset_gate_polarity       <= `CCDH_RST_POL; // [RULE4]
            reset_gate_rise_position  <= `CCDH_RST_RG_RISE; // [RULE5]
            reset_gate_fall_position  <= `CCDH_RST_RG_FALL; // [RULE5]
            reset_gate_drive_strength <= `CCDH_RST_RG_DRV; // [RULE6]
            reference_sample_position <= `CCDH_RST_REF_POS; // [RULE7]
            data_sample_position      <= `CCDH_RST_DAT_POS; // [RULE7]
        end else if (wr_en) begin
            case (wr_addr)
                `CCDH_ADDR_OPMODE_LO: begin
                    operating_mode[5:0] <= wr_data[5:0]; // [RULE8] [RULE11]
                end
                `CCDH_ADDR_OPMODE_HI: begin
                    operating_mode[7:6] <= wr_data[1:0]; // [RULE8]
                end
                `CCDH_ADDR_CTLMODE: begin
                    control_mode <= wr_data[5:0]; // [RULE12]
                end
                `CCDH_ADDR_HA_POL: begin
                    hclk_a_polarity <= wr_data[0]; // [RULE1]
                end
                `CCDH_ADDR_HA_RISE: begin
                    hclk_a_rise_position <= wr_data[5:0]; // [RULE2]
                end
                `CCDH_ADDR_HA_FALL: begin
                    hclk_a_fall_position <= wr_data[5:0]; // [RULE2]
                end
                `CCDH_ADDR_HA_DRV: begin
                    hclk_a_drive_strength <= wr_data[2:0]; // [RULE3]
                end
                `CCDH_ADDR_HA_INV_DRV: begin
                    hclk_a_inv_drive_strength <= wr_data[2:0]; // [RULE3]
                end
                `CCDH_ADDR_HB_DRV: begin
                    hclk_b_drive_strength <= wr_data[2:0]; // [RULE3]
                end
                `CCDH_ADDR_HB_INV_DRV: begin
                    hclk_b_inv_drive_strength <= wr_data[2:0]; // [RULE3]
                end
                `CCDH_ADDR_RG_POL: begin
                    reset_gate_polarity <= wr_data[0]; // [RULE4]
                end
                `CCDH_ADDR_RG_RISE: begin
                    reset_gate_rise_position <= wr_data[5:0]; // [RULE5]
                end
                `CCDH_ADDR_RG_FALL: begin
                    reset_gate_fall_position <= wr_data[5:0]; // [RULE5]
                end
                `CCDH_ADDR_RG_DRV: begin
                    reset_gate_drive_strength <= wr_data[2:0]; // [RULE6]
                end
                `CCDH_ADDR_REF_POS: begin
                    reference_sample_position <= wr_data[5:0]; // [RULE7]
                end
                `CCDH_ADDR_DAT_POS: begin
                    data_sample_position <= wr_data[5:0]; // [RULE7]
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // read-back
    // ****************************************
    always @* begin
        next_rd_data = 8'h00;
        case (rd_addr)
            `CCDH_ADDR_OPMODE_LO:  next_rd_data = {2'h0, operating_mode[5:0]};
            `CCDH_ADDR_OPMODE_HI:  next_rd_data = {6'h00, operating_mode[7:6]};
            `CCDH_ADDR_CTLMODE:    next_rd_data = {2'h0, control_mode};
            `CCDH_ADDR_HA_POL:     next_rd_data = {7'h00, hclk_a_polarity};
            `CCDH_ADDR_HA_RISE:    next_rd_data = {2'h0, hclk_a_rise_position};
            `CCDH_ADDR_HA_FALL:    next_rd_data = {2'h0, hclk_a_fall_position};
            `CCDH_ADDR_HA_DRV:     next_rd_data = {5'h00, hclk_a_drive_strength};
            `CCDH_ADDR_HA_INV_DRV: next_rd_data = {5'h00, hclk_a_inv_drive_strength};
            `CCDH_ADDR_HB_DRV:     next_rd_data = {5'h00, hclk_b_drive_strength};
            `CCDH_ADDR_HB_INV_DRV: next_rd_data = {5'h00, hclk_b_inv_drive_strength};
            `CCDH_ADDR_RG_POL:     next_rd_data = {7'h00, reset_gate_polarity};
            `CCDH_ADDR_RG_RISE:    next_rd_data = {2'h0, reset_gate_rise_position};
            `CCDH_ADDR_RG_FALL:    next_rd_data = {2'h0, reset_gate_fall_position};
            `CCDH_ADDR_RG_DRV:     next_rd_data = {5'h00, reset_gate_drive_strength};
            `CCDH_ADDR_REF_POS:    next_rd_data = {2'h0, reference_sample_position};
            `CCDH_ADDR_DAT_POS:    next_rd_data = {2'h0, data_sample_position};
            default:               next_rd_data = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en)
                rd_data <= next_rd_data;
        end
    end

    // ****************************************
    // 48-step edge grid
    // ****************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step      <= 6'h00;
            edge_step <= 6'h00;
        end else begin
            if (pixel_start || step == `CCDH_EDGES - 6'h01)
                step <= 6'h00; // [RULE17]
            else
                step <= step + 6'h01; // [RULE17]
            edge_step <= step;
        end
    end

    // strobes are one grid step wide from any sample position but step 47, where they never fall
    assign ref_fall = reference_sample_position + 6'h01;
    assign dat_fall = data_sample_position + 6'h01;

    ccdh_edge_gen u_edge_ha (
        .clk      (clk),
        .rstn     (rstn),
        .rise_pos (hclk_a_rise_position),
        .fall_pos (hclk_a_fall_position),
        .invert   (hclk_a_polarity),
        .step     (step),
        .wave     (wave_ha)
    );

    ccdh_edge_gen u_edge_rg (
        .clk      (clk),
        .rstn     (rstn),
        .rise_pos (reset_gate_rise_position),
        .fall_pos (reset_gate_fall_position),
        .invert   (reset_gate_polarity),
        .step     (step),
        .wave     (wave_rg)
    );

    ccdh_edge_gen u_edge_ref (
        .clk      (clk),
        .rstn     (rstn),
        .rise_pos (reference_sample_position),
        .fall_pos (ref_fall),
        .invert   (1'b0),
        .step     (step),
        .wave     (wave_ref)
    );

    ccdh_edge_gen u_edge_dat (
        .clk      (clk),
        .rstn     (rstn),
        .rise_pos (data_sample_position),
        .fall_pos (dat_fall),
        .invert   (1'b0),
        .step     (step),
        .wave     (wave_dat)
    );

    // ****************************************
    // output stage
    // ****************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hclk_phase_a            <= 1'b0;
            hclk_phase_a_inv        <= 1'b1;
            hclk_phase_b            <= 1'b0;
            hclk_phase_b_inv        <= 1'b1;
            reset_gate_clk          <= 1'b0;
            reference_sample_strobe <= 1'b0;
            data_sample_strobe      <= 1'b0;
            hclk_a_drv              <= `CCDH_RST_H_DRV;
            hclk_a_inv_drv          <= `CCDH_RST_H_DRV;
            hclk_b_drv              <= `CCDH_RST_H_DRV;
            hclk_b_inv_drv          <= `CCDH_RST_H_DRV;
            reset_gate_drv          <= `CCDH_RST_RG_DRV;
            hclk_a_drv_en           <= 1'b1;
            hclk_a_inv_drv_en       <= 1'b1;
            hclk_b_drv_en           <= 1'b1;
            hclk_b_inv_drv_en       <= 1'b1;
            reset_gate_drv_en       <= 1'b1;
            power_state             <= `CCDH_PWR_FULL;
            power_full              <= 1'b1;
            power_fast_recovery     <= 1'b0;
            power_ref_standby       <= 1'b0;
            power_shutdown          <= 1'b0;
            black_clamp_en          <= 1'b1;
            color_mode              <= 3'h0;
            pixel_gain_amp_en       <= 1'b0;
            output_latch_en         <= 1'b0;
            adc_out_en              <= 1'b1;
        end else begin
            // phase B shares the phase-A waveform
            hclk_phase_a            <= wave_ha; // [RULE1] [RULE20]
            hclk_phase_a_inv        <= ~wave_ha; // [RULE19]
            hclk_phase_b            <= wave_ha;
            hclk_phase_b_inv        <= ~wave_ha; // [RULE19]
            reset_gate_clk          <= wave_rg; // [RULE4] [RULE20]
            reference_sample_strobe <= wave_ref; // [RULE7]
            data_sample_strobe      <= wave_dat; // [RULE7]
            hclk_a_drv              <= hclk_a_drive_strength; // [RULE3]
            hclk_a_inv_drv          <= hclk_a_inv_drive_strength; // [RULE3]
            hclk_b_drv              <= hclk_b_drive_strength; // [RULE3]
            hclk_b_inv_drv          <= hclk_b_inv_drive_strength; // [RULE3]
            reset_gate_drv          <= reset_gate_drive_strength; // [RULE6]
            hclk_a_drv_en           <= |hclk_a_drive_strength; // [RULE3]
            hclk_a_inv_drv_en       <= |hclk_a_inv_drive_strength; // [RULE3]
            hclk_b_drv_en           <= |hclk_b_drive_strength; // [RULE3]
            hclk_b_inv_drv_en       <= |hclk_b_inv_drive_strength; // [RULE3]
            reset_gate_drv_en       <= |reset_gate_drive_strength; // [RULE6]
            power_state             <= operating_mode[`CCDH_OP_PWR_MSB:`CCDH_OP_PWR_LSB]; // [RULE9]
            power_full              <= operating_mode[1:0] == `CCDH_PWR_FULL; // [RULE9]
            power_fast_recovery     <= operating_mode[1:0] == `CCDH_PWR_FAST; // [RULE9]
            power_ref_standby       <= operating_mode[1:0] == `CCDH_PWR_STANDBY; // [RULE9]
            power_shutdown          <= operating_mode[1:0] == `CCDH_PWR_OFF; // [RULE9]
            black_clamp_en          <= ~operating_mode[`CCDH_OP_NOCLAMP]; // [RULE10]
            color_mode              <= control_mode[`CCDH_CM_COLOR_MSB:`CCDH_CM_COLOR_LSB]; // [RULE13]
            pixel_gain_amp_en       <= control_mode[`CCDH_CM_GAIN_EN]; // [RULE14]
            output_latch_en         <= control_mode[`CCDH_CM_LATCH]; // [RULE15]
            adc_out_en              <= ~control_mode[`CCDH_CM_HIZ]; // [RULE16]
        end
    end

endmodule

/* File: pkg/ccdh_consts.vh */
`ifndef CCDH_CONSTS_VH
`define CCDH_CONSTS_VH

// ****************************************
// serial register addresses
// ****************************************
`define CCDH_ADDR_OPMODE_LO   8'h00
`define CCDH_ADDR_OPMODE_HI   8'h01
`define CCDH_ADDR_CTLMODE     8'h06
`define CCDH_ADDR_HA_POL      8'he5
`define CCDH_ADDR_HA_RISE     8'he6
`define CCDH_ADDR_HA_FALL     8'he7
`define CCDH_ADDR_HA_DRV      8'he8
`define CCDH_ADDR_HA_INV_DRV  8'he9
`define CCDH_ADDR_HB_DRV      8'hea
`define CCDH_ADDR_HB_INV_DRV  8'heb
`define CCDH_ADDR_RG_POL      8'hec
`define CCDH_ADDR_RG_RISE     8'hed
`define CCDH_ADDR_RG_FALL     8'hee
`define CCDH_ADDR_RG_DRV      8'hef
`define CCDH_ADDR_REF_POS     8'hf0
`define CCDH_ADDR_DAT_POS     8'hf1

// ****************************************
// reset values
// ****************************************
`define CCDH_RST_OPMODE       8'h00
`define CCDH_RST_CTLMODE      6'h00
`define CCDH_RST_POL          1'h0
`define CCDH_RST_HA_RISE      6'h00
`define CCDH_RST_HA_FALL      6'h20
`define CCDH_RST_H_DRV        3'h3
`define CCDH_RST_RG_RISE      6'h00
`define CCDH_RST_RG_FALL      6'h10
`define CCDH_RST_RG_DRV       3'h2
`define CCDH_RST_REF_POS      6'h24
`define CCDH_RST_DAT_POS      6'h00

// ****************************************
// field positions
// ****************************************
`define CCDH_OP_PWR_MSB       1
`define CCDH_OP_PWR_LSB       0
`define CCDH_OP_NOCLAMP       2
`define CCDH_OP_LO_WIDTH      6
`define CCDH_CM_COLOR_MSB     2
`define CCDH_CM_COLOR_LSB     0
`define CCDH_CM_GAIN_EN       3
`define CCDH_CM_LATCH         4
`define CCDH_CM_HIZ           5

// ****************************************
// power states and edge grid
// ****************************************
`define CCDH_PWR_FULL         2'h0
`define CCDH_PWR_FAST         2'h1
`define CCDH_PWR_STANDBY      2'h2
`define CCDH_PWR_OFF          2'h3
`define CCDH_EDGES            6'h30
`define CCDH_QUAD_SIZE        6'h0c

`endif

/* File: hdl/ccdh_edge_gen.v */
`timescale 1ns/1ps
`include "ccdh_consts.vh"

// one programmable edge waveform on the 48-step pixel grid
module ccdh_edge_gen (
    // clock and reset
    input  wire       clk,
    input  wire       rstn,
    // settings
    input  wire [5:0] rise_pos,
    input  wire [5:0] fall_pos,
    input  wire       invert,
    // grid position
    input  wire [5:0] step,
    // waveform
    output reg        wave
);

    reg        level;
    reg        next_level;
    wire [5:0] rise_lin;
    wire [5:0] fall_lin;

    // quadrant in the upper bits, 0..11 in the lower
    assign rise_lin = rise_pos[5:4] * `CCDH_QUAD_SIZE + {2'h0, rise_pos[3:0]}; // [RULE18]
    assign fall_lin = fall_pos[5:4] * `CCDH_QUAD_SIZE + {2'h0, fall_pos[3:0]}; // [RULE18]

    always @* begin
        next_level = level;
        if (step == rise_lin)
            next_level = 1'b1; // [RULE20]
        if (step == fall_lin)
            next_level = 1'b0; // [RULE20]
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level <= 1'b0;
            wave  <= 1'b0;
        end else begin
            level <= next_level;
            wave  <= next_level ^ invert; // [RULE1] [RULE4]
        end
    end

endmodule

/* File: tb/ccdh_ccd_model.sv */
`timescale 1ns/1ps
// ****************************************
// sensor-side pin monitor
// ****************************************
module ccdh_ccd_model (
    // clock
    input  wire clk,
    // clocks arriving at the sensor
    input  wire hclk_phase_a,
    input  wire reset_gate_clk,
    input  wire reference_sample_strobe,
    // measured timing, in grid steps
    output int  hclk_high,
    output int  rg_high,
    output int  hclk_ofs,
    output int  ref_ofs
);
    int   run_h;
    int   run_r;
    int   since_rg;
    int   cur;
    logic h_q;
    logic r_q;
    logic s_q;

    initial begin
        {run_h, run_r, since_rg, hclk_high, rg_high, hclk_ofs, ref_ofs} = '0;
        {h_q, r_q, s_q} = 3'h0;
    end

    // offsets count from the last reset-gate rise
    always @(posedge clk) begin
        cur = (reset_gate_clk && !r_q) ? 0 : since_rg + 1;
        since_rg = cur;
        if (hclk_phase_a && !h_q) hclk_ofs = cur;
        if (reference_sample_strobe && !s_q) ref_ofs = cur;
        if (!hclk_phase_a && h_q) hclk_high = run_h;
        if (!reset_gate_clk && r_q) rg_high = run_r;
        run_h = hclk_phase_a ? run_h + 1 : 0;
        run_r = reset_gate_clk ? run_r + 1 : 0;
        h_q = hclk_phase_a;
        r_q = reset_gate_clk;
        s_q = reference_sample_strobe;
    end
endmodule

/* File: tb/ccdh_config_properties.sv */
`timescale 1ns/1ps
// ****************************************
// register bank checks
// ****************************************
module ccdh_config_properties (
    // clock and reset
    input wire       clk,
    input wire       rstn,
    // register port
    input wire       wr_en,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data,
    input wire       rd_en,
    input wire [7:0] rd_addr,
    input wire [7:0] rd_data,
    input wire       rd_valid,
    // grid and pins
    input wire [5:0] edge_step,
    input wire       hclk_phase_a,
    input wire       hclk_phase_a_inv,
    input wire       hclk_phase_b,
    input wire       hclk_phase_b_inv,
    // drivers and modes
    input wire [2:0] hclk_a_drv,
    input wire       hclk_a_drv_en,
    input wire [2:0] reset_gate_drv,
    input wire       reset_gate_drv_en,
    input wire [1:0] power_state,
    input wire       power_full,
    input wire       power_shutdown,
    input wire       black_clamp_en,
    input wire       pixel_gain_amp_en,
    input wire       adc_out_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    read_answer_a: assert property (rd_en |=> rd_valid)
        else $error("read not answered");
    read_idle_a: assert property (!rd_en |=> !rd_valid)
        else $error("read valid without request");
    unmapped_zero_a: assert property (rd_en &&
        rd_addr inside {[8'h02:8'h05], [8'h07:8'he4]} |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    hclk_a_comp_a: assert property (hclk_phase_a_inv != hclk_phase_a)
        else $error("phase A pair not complementary");
    hclk_b_comp_a: assert property (hclk_phase_b_inv != hclk_phase_b)
        else $error("phase B pair not complementary");
    drv_off_a: assert property (hclk_a_drv_en == (hclk_a_drv != 3'h0))
        else $error("phase A driver enable wrong");
    rg_drv_off_a: assert property (reset_gate_drv_en == (reset_gate_drv != 3'h0))
        else $error("reset gate driver enable wrong");
    power_decode_a: assert property (power_shutdown == (power_state == 2'h3)
        && power_full == (power_state == 2'h0)) else $error("power decode wrong");
    gain_write_a: assert property (wr_en && wr_addr == 8'h06
        |-> ##2 pixel_gain_amp_en == $past(wr_data[3], 2)) else $error("gain enable wrong");
    tristate_write_a: assert property (wr_en && wr_addr == 8'h06
        |-> ##2 adc_out_en == !$past(wr_data[5], 2)) else $error("output enable wrong");
    clamp_write_a: assert property (wr_en && wr_addr == 8'h00
        |-> ##2 black_clamp_en == !$past(wr_data[2], 2)) else $error("clamp enable wrong");
    grid_wrap_a: assert property (edge_step == 6'h2f |=> edge_step == 6'h00)
        else $error("grid did not wrap after 47");
    grid_range_a: assert property (edge_step < 6'h30)
        else $error("grid step out of range");
endmodule

bind ccdh_config ccdh_config_properties i_props (
    .clk(clk), .rstn(rstn), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .edge_step(edge_step), .hclk_phase_a(hclk_phase_a), .hclk_phase_a_inv(hclk_phase_a_inv),
    .hclk_phase_b(hclk_phase_b), .hclk_phase_b_inv(hclk_phase_b_inv),
    .hclk_a_drv(hclk_a_drv), .hclk_a_drv_en(hclk_a_drv_en), .reset_gate_drv(reset_gate_drv),
    .reset_gate_drv_en(reset_gate_drv_en), .power_state(power_state),
    .power_full(power_full), .power_shutdown(power_shutdown),
    .black_clamp_en(black_clamp_en), .pixel_gain_amp_en(pixel_gain_amp_en),
    .adc_out_en(adc_out_en)
);

/* File: tb/tb.sv */
`timescale 1ns/1ps
// ****************************************
// register bank bench
// ****************************************
module tb;
    typedef struct packed { logic [7:0] a, rst, d, exp; } ccdh_row_t;

    logic       clk, rstn, wr_en, rd_en, pixel_start;
    logic [7:0] wr_addr, wr_data, rd_addr;
    wire  [7:0] rd_data;
    wire  [2:0] color_mode;
    wire        rd_valid, hclk_phase_a, hclk_phase_a_inv, reset_gate_clk, reference_sample_strobe;
    wire        power_full, power_fast_recovery, power_ref_standby, power_shutdown;
    wire        black_clamp_en, pixel_gain_amp_en, output_latch_en, adc_out_en;
    wire        hclk_a_drv_en, reset_gate_drv_en;
    int         mismatches, samples_checked, hclk_high, rg_high, hclk_ofs, ref_ofs;

    // address, reset value, write data, value read back
    ccdh_row_t  rows [17] = '{
        '{8'h00, 8'h00, 8'h17, 8'h17}, '{8'h01, 8'h00, 8'hfc, 8'h00},
        '{8'h06, 8'h00, 8'hfa, 8'h3a}, '{8'he5, 8'h00, 8'hff, 8'h01},
        '{8'he6, 8'h00, 8'h2b, 8'h2b}, '{8'he7, 8'h20, 8'h3b, 8'h3b},
        '{8'he8, 8'h03, 8'h00, 8'h00}, '{8'he9, 8'h03, 8'h07, 8'h07},
        '{8'hea, 8'h03, 8'hff, 8'h07}, '{8'heb, 8'h03, 8'h01, 8'h01},
        '{8'hec, 8'h00, 8'hfe, 8'h00}, '{8'hed, 8'h00, 8'h1a, 8'h1a},
        '{8'hee, 8'h10, 8'h3a, 8'h3a}, '{8'hef, 8'h02, 8'h00, 8'h00},
        '{8'hf0, 8'h24, 8'h11, 8'h11}, '{8'hf1, 8'h00, 8'h30, 8'h30},
        '{8'h02, 8'h00, 8'h55, 8'h00}};

    ccdh_config i_dut (
        .clk(clk), .rstn(rstn), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .pixel_start(pixel_start), .edge_step(), .hclk_phase_a(hclk_phase_a),
        .hclk_phase_a_inv(hclk_phase_a_inv), .hclk_phase_b(), .hclk_phase_b_inv(),
        .reset_gate_clk(reset_gate_clk), .reference_sample_strobe(reference_sample_strobe),
        .data_sample_strobe(), .hclk_a_drv(), .hclk_a_inv_drv(), .hclk_b_drv(),
        .hclk_b_inv_drv(), .reset_gate_drv(), .hclk_a_drv_en(hclk_a_drv_en),
        .hclk_a_inv_drv_en(), .hclk_b_drv_en(), .hclk_b_inv_drv_en(),
        .reset_gate_drv_en(reset_gate_drv_en), .power_state(), .power_full(power_full),
        .power_fast_recovery(power_fast_recovery), .power_ref_standby(power_ref_standby),
        .power_shutdown(power_shutdown), .black_clamp_en(black_clamp_en),
        .color_mode(color_mode), .pixel_gain_amp_en(pixel_gain_amp_en),
        .output_latch_en(output_latch_en), .adc_out_en(adc_out_en)
    );

    ccdh_ccd_model i_ccd (
        .clk(clk), .hclk_phase_a(hclk_phase_a), .reset_gate_clk(reset_gate_clk),
        .reference_sample_strobe(reference_sample_strobe), .hclk_high(hclk_high),
        .rg_high(rg_high), .hclk_ofs(hclk_ofs), .ref_ofs(ref_ofs)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // leaves the write strobe up so writes can run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
    endtask

    task automatic idle;
        @(negedge clk);
        wr_en = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        check({7'h0, rd_valid}, 8'h01);
        check(rd_data, exp);
    endtask

    initial begin
        #1ms;
        mismatches++;
        wrap_up();
    end

    initial begin
        {rstn, wr_en, rd_en, pixel_start} = 4'h0;
        {wr_addr, wr_data, rd_addr} = '0;
        repeat (12) @(negedge clk);
        check({power_full, black_clamp_en, adc_out_en, hclk_a_drv_en, reset_gate_drv_en,
               pixel_gain_amp_en, power_shutdown, output_latch_en}, 8'hf8);
        rstn = 1'b1;
        @(negedge clk);
        pixel_start = 1'b1;
        @(negedge clk);
        pixel_start = 1'b0;
        repeat (100) @(negedge clk);
        check(hclk_high[7:0], 8'h18);
        check(rg_high[7:0], 8'h0c);
        check(hclk_ofs[7:0], 8'h00);
        check(ref_ofs[7:0], 8'h1c);
        foreach (rows[i]) begin
            rd(rows[i].a, rows[i].rst);
            wr(rows[i].a, rows[i].d);
            idle();
            rd(rows[i].a, rows[i].exp);
        end
        check({power_shutdown, black_clamp_en, hclk_a_drv_en, reset_gate_drv_en,
               pixel_gain_amp_en, output_latch_en, adc_out_en, 1'b0}, 8'h8c);
        repeat (100) @(negedge clk);
        check(hclk_high[7:0], 8'h24);
        check(rg_high[7:0], 8'h18);
        check(ref_ofs[7:0], 8'h27);
        wr(8'hec, 8'h01);
        idle();
        repeat (100) @(negedge clk);
        check(ref_ofs[7:0], 8'h0f);
        for (int p = 0; p < 4; p++) begin
            wr(8'h00, 8'h10 | p[7:0]);
            idle();
            @(negedge clk);
            check({4'h0, power_shutdown, power_ref_standby, power_fast_recovery, power_full},
                  8'h01 << p);
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'h06, 8'h20 | c[7:0]);
            idle();
            @(negedge clk);
            check({adc_out_en, pixel_gain_amp_en, output_latch_en, 2'h0, color_mode},
                  {5'h0, c[2:0]});
        end
        wr(8'h06, 8'h18);
        wr(8'h00, 8'h16);
        wr(8'he8, 8'h01);
        idle();
        @(negedge clk);
        check({3'h0, output_latch_en, pixel_gain_amp_en, black_clamp_en, hclk_a_drv_en,
               power_ref_standby}, 8'h1b);
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        rd(8'he7, 8'h20);
        rd(8'hef, 8'h02);
        rd(8'h06, 8'h00);
        wrap_up();
    end
endmodule
